//--- inc/err_init_defines.vh
`ifndef ERR_INIT_DEFINES_VH
`define ERR_INIT_DEFINES_VH

// Synchroniser depth for asynchronous pins
`define SYNC_STAGES      2
// Snoop stall length in bus clocks per request
`define STALL_CYCLES     4'h2
// Self-test duration in bus clocks
`define BUILT_IN_SELF_TEST_CYCLES      8'h10
// Integer register reset sequence length
`define INIT_CYCLES      4'h4
// Edge after reset release at which the synced strap is judged
`define STRAP_EDGE       2'h2
// Reset values
`define FLAG_RESET       1'b0

`endif

//--- logic/pin_sync.v
`default_nettype none
// ----------------------------------------
// Two-stage level synchroniser, WIDTH bits
// ----------------------------------------
module pin_sync #(
    parameter WIDTH = 2
) (
    input  wire             clk,
    input  wire             rst_b,
    input  wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            // Two flops per bit, first read only by second
            always @(posedge clk) begin
                if (!rst_b) begin
                    meta_q[i] <= 1'b0;
                    sync_q[i] <= 1'b0;
                end else begin
                    meta_q[i] <= async_in[i];
                    sync_q[i] <= meta_q[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_q;
endmodule
`default_nettype wire

//--- logic/err_init_unit.v
// Function
// (RULE_01) Shared output reports unmasked FP error
// (RULE_02) Stop-clock active: output signals pending break
// (RULE_03) Break indication holds until stop-clock drops
// (RULE_04) Probe request under stop-clock is break
// (RULE_05) Snoop stall asserts hit and snoop_hit_modified together
// (RULE_06) Internal error asserts internal-error output
// (RULE_07) Internal error held until reset/init
// (RULE_08) Ignore input set: pending error ignored
// (RULE_09) Ignore input clear: error raises exception
// (RULE_10) Native error bit disables ignore input
// (RULE_11) System sets async inputs before target-ready
// (RULE_12) Warm init resets integer regs, restarts
// (RULE_13) Snoops serviced during warm init
// (RULE_14) Init at reset release starts self-test
// (RULE_15) Async inputs pass two-stage synchroniser
`include "err_init_defines.vh"
`default_nettype none
module err_init_unit (
    input  wire CLK_SYS,
    input  wire RST_B,
    input  wire STOP_CLOCK_REQ,
    input  wire PROBE_REQUEST,
    input  wire IGNORE_NUMERIC_ERROR,
    input  wire WARM_INIT,
    input  wire BUS_INIT,
    input  wire NATIVE_ERROR_BIT,
    input  wire FP_ERROR_EVENT,
    input  wire FP_NONCTRL_ISSUE,
    input  wire INTERNAL_ERROR_EVENT,
    input  wire SNOOP_REQ,
    input  wire SNOOP_NEED_STALL,
    input  wire SNOOP_HIT_IN,
    input  wire SNOOP_HIT_MODIFIED_IN,
    output reg  FP_ERROR_OUT,
    output reg  INTERNAL_ERROR_OUT,
    output reg  SHUTDOWN_REQ,
    output reg  FP_EXCEPTION,
    output reg  SNOOP_HIT_OUT,
    output reg  SNOOP_HIT_OE,
    output reg  SNOOP_HIT_MODIFIED_OUT,
    output reg  SNOOP_HIT_MODIFIED_OE,
    output reg  SNOOP_DONE,
    output reg  PEER_STALL_SEEN,
    output reg  INT_REG_RESET,
    output reg  START_AT_RESET_VECTOR,
    output reg  BUILT_IN_SELF_TEST_RUN
);
    // ----------------------------------------
    // Synchronisers for asynchronous pins
    // ----------------------------------------
    wire [5:0] sync_w;
    // (RULE_15) Two-flop synchroniser instance
    pin_sync #(.WIDTH(6)) u_sync (
        .clk      (CLK_SYS),
        .rst_b    (RST_B),
        .async_in ({STOP_CLOCK_REQ, PROBE_REQUEST, IGNORE_NUMERIC_ERROR,
                    WARM_INIT, SNOOP_HIT_IN, SNOOP_HIT_MODIFIED_IN}),
        .sync_out (sync_w)
    );
    wire stop_clock_req_s = sync_w[5];
    wire probe_s  = sync_w[4];
    wire ignore_numeric_error_s  = sync_w[3];
    wire init_s   = sync_w[2];
    wire hit_s    = sync_w[1];
    wire snoop_hit_modified_s   = sync_w[0];

    // ----------------------------------------
    // Floating-point error and break event
    // ----------------------------------------
    reg fp_pend_q;
    reg brk_q;
    reg init_prev_q;
    wire init_rise = init_s & ~init_prev_q;
    // (RULE_10) Native reporting masks ignore input
    wire ignore_eff = ignore_numeric_error_s & ~NATIVE_ERROR_BIT;

    // Pending FP error, set wins over clear
    always @(posedge CLK_SYS) begin
        if (!RST_B) begin
            fp_pend_q <= `FLAG_RESET;
        end else if (FP_ERROR_EVENT) begin
            fp_pend_q <= 1'b1;
        end else if (init_rise) begin
            fp_pend_q <= 1'b0;
        end
    end

    // (RULE_03) Break latch held until stop-clock drops
    always @(posedge CLK_SYS) begin
        if (!RST_B) begin
            brk_q <= `FLAG_RESET;
        end else if (!stop_clock_req_s) begin
            brk_q <= 1'b0;
        end else if (probe_s || fp_pend_q) begin
            // (RULE_04) Probe request is break event
            brk_q <= 1'b1;
        end
    end

    // (RULE_01) (RULE_02) Output meaning follows stop-clock
    always @(posedge CLK_SYS) begin
        if (!RST_B) begin
            FP_ERROR_OUT <= `FLAG_RESET;
        end else if (stop_clock_req_s) begin
            FP_ERROR_OUT <= brk_q | probe_s | fp_pend_q;
        end else begin
            FP_ERROR_OUT <= fp_pend_q;
        end
    end

    // (RULE_08) (RULE_09) Exception unless error ignored
    always @(posedge CLK_SYS) begin
        if (!RST_B) begin
            FP_EXCEPTION <= `FLAG_RESET;
        end else begin
            FP_EXCEPTION <= FP_NONCTRL_ISSUE & fp_pend_q & ~ignore_eff;
        end
    end

    // ----------------------------------------
    // Internal error
    // ----------------------------------------
    // (RULE_06) (RULE_07) Sticky until reset or init
    always @(posedge CLK_SYS) begin
        if (!RST_B) begin
            INTERNAL_ERROR_OUT <= `FLAG_RESET;
            SHUTDOWN_REQ       <= `FLAG_RESET;
        end else begin
            SHUTDOWN_REQ <= INTERNAL_ERROR_EVENT & ~INTERNAL_ERROR_OUT;
            if (INTERNAL_ERROR_EVENT) begin
                INTERNAL_ERROR_OUT <= 1'b1;
            end else if (BUS_INIT || init_s) begin
                INTERNAL_ERROR_OUT <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Snoop stall
    // ----------------------------------------
    reg [3:0] stall_q;
    // (RULE_05) Drive hit and snoop_hit_modified together for stall
    always @(posedge CLK_SYS) begin
        if (!RST_B) begin
            stall_q                <= 4'h0;
            SNOOP_HIT_OUT          <= 1'b0;
            SNOOP_HIT_OE           <= 1'b0;
            SNOOP_HIT_MODIFIED_OUT <= 1'b0;
            SNOOP_HIT_MODIFIED_OE  <= 1'b0;
            SNOOP_DONE             <= 1'b0;
            PEER_STALL_SEEN        <= 1'b0;
        end else begin
            PEER_STALL_SEEN <= hit_s & snoop_hit_modified_s;
            SNOOP_DONE      <= 1'b0;
            if (stall_q != 4'h0) begin
                stall_q <= stall_q - 4'h1;
            end else if (SNOOP_REQ && SNOOP_NEED_STALL) begin
                stall_q <= `STALL_CYCLES;
            end else if (SNOOP_REQ) begin
                // (RULE_13) Snoop answered even during init
                SNOOP_DONE <= 1'b1;
            end
            SNOOP_HIT_OUT          <= (stall_q != 4'h0);
            SNOOP_HIT_OE           <= (stall_q != 4'h0);
            SNOOP_HIT_MODIFIED_OUT <= (stall_q != 4'h0);
            SNOOP_HIT_MODIFIED_OE  <= (stall_q != 4'h0);
        end
    end

    // ----------------------------------------
    // Warm init and self-test
    // ----------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_INIT = 2'b01;
    localparam ST_BUILT_IN_SELF_TEST = 2'b10;
    reg [1:0] state_q;
    reg [7:0] cnt_q;
    reg [1:0] rst_cnt_q;

    always @(posedge CLK_SYS) begin
        if (!RST_B) begin
            state_q               <= ST_IDLE;
            cnt_q                 <= 8'h00;
            init_prev_q           <= 1'b0;
            rst_cnt_q             <= 2'h0;
            INT_REG_RESET         <= 1'b0;
            START_AT_RESET_VECTOR <= 1'b0;
            BUILT_IN_SELF_TEST_RUN              <= 1'b0;
        end else begin
            init_prev_q           <= init_s;
            START_AT_RESET_VECTOR <= 1'b0;
            // Wait until the strap level has crossed the synchroniser
            if (rst_cnt_q != 2'h3) begin
                rst_cnt_q <= rst_cnt_q + 2'h1;
            end
            case (state_q)
                ST_IDLE: begin
                    // (RULE_14) Init at reset release runs self-test
                    if ((rst_cnt_q == `STRAP_EDGE) && init_s) begin
                        state_q  <= ST_BUILT_IN_SELF_TEST;
                        cnt_q    <= `BUILT_IN_SELF_TEST_CYCLES - 8'h01;
                        BUILT_IN_SELF_TEST_RUN <= 1'b1;
                    end else if (init_rise) begin
                        // (RULE_12) Reset integer registers only
                        state_q       <= ST_INIT;
                        cnt_q         <= {4'h0, `INIT_CYCLES};
                        INT_REG_RESET <= 1'b1;
                    end
                end
                ST_INIT: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else if (!init_s) begin
                        state_q               <= ST_IDLE;
                        INT_REG_RESET         <= 1'b0;
                        START_AT_RESET_VECTOR <= 1'b1;
                    end
                end
                ST_BUILT_IN_SELF_TEST: begin
                    if (cnt_q != 8'h00) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else begin
                        state_q               <= ST_IDLE;
                        BUILT_IN_SELF_TEST_RUN              <= 1'b0;
                        START_AT_RESET_VECTOR <= 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- testbench/err_init_props.sv
`default_nettype none
module err_init_props (
    input wire logic CLK_SYS,
    input wire logic RST_B,
    input wire logic STOP_CLOCK_REQ,
    input wire logic PROBE_REQUEST,
    input wire logic BUS_INIT,
    input wire logic WARM_INIT,
    input wire logic FP_ERROR_EVENT,
    input wire logic FP_NONCTRL_ISSUE,
    input wire logic INTERNAL_ERROR_EVENT,
    input wire logic FP_ERROR_OUT,
    input wire logic FP_EXCEPTION,
    input wire logic INTERNAL_ERROR_OUT,
    input wire logic SNOOP_HIT_OUT,
    input wire logic SNOOP_HIT_MODIFIED_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);
    // Stop-clock settled through the synchroniser
    sequence s_stop_on;
        STOP_CLOCK_REQ [*4];
    endsequence
    a_fp_set: assert property (FP_ERROR_EVENT |=> ##1 FP_ERROR_OUT)
        else $error("fp flag late");
    a_break_hold: assert property (s_stop_on ##0 FP_ERROR_OUT |=> FP_ERROR_OUT)
        else $error("break flag dropped");
    a_probe_break: assert property (s_stop_on ##0
        (PROBE_REQUEST && STOP_CLOCK_REQ) [*3] |-> ##[0:2] FP_ERROR_OUT)
        else $error("probe break missed");
    a_internal_error_out_set: assert property (INTERNAL_ERROR_EVENT |=> INTERNAL_ERROR_OUT)
        else $error("internal error missed");
    a_internal_error_out_hold: assert property (INTERNAL_ERROR_OUT && !BUS_INIT && !WARM_INIT
        && !$past(WARM_INIT) && !$past(WARM_INIT, 2) |=> INTERNAL_ERROR_OUT)
        else $error("internal error dropped");
    a_hit_pair: assert property (SNOOP_HIT_OUT == SNOOP_HIT_MODIFIED_OUT)
        else $error("hit pair split");
    a_stall_len: assert property ($rose(SNOOP_HIT_OUT) |->
        SNOOP_HIT_OUT [*2] ##1 !SNOOP_HIT_OUT)
        else $error("stall length wrong");
    a_fpx_cause: assert property (FP_EXCEPTION |-> $past(FP_NONCTRL_ISSUE))
        else $error("exception without issue");
endmodule
bind err_init_unit err_init_props u_props (.*);
`default_nettype wire

//--- testbench/peer_agent.sv
`default_nettype none
module peer_agent (
    input  wire logic clk,
    input  wire logic stall_req,
    input  wire logic ign_req,
    input  wire logic init_req,
    output var  logic hit,
    output var  logic snoop_hit_modified,
    output var  logic ign,
    output var  logic init
);
    timeunit 1ns;
    timeprecision 1ns;
    always @(posedge clk) begin
        hit  <= stall_req;
        snoop_hit_modified <= stall_req;
        ign  <= ign_req;
        init <= init_req;
    end
endmodule
`default_nettype wire

//--- testbench/err_init_unit_tb.sv
`include "err_init_defines.vh"
`default_nettype none
module err_init_unit_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK_SYS = 1'b0, RST_B = 1'b0, STOP_CLOCK_REQ = 1'b0, PROBE_REQUEST = 1'b0;
    logic BUS_INIT = 1'b0, NATIVE_ERROR_BIT = 1'b0, FP_ERROR_EVENT = 1'b0;
    logic FP_NONCTRL_ISSUE = 1'b0, INTERNAL_ERROR_EVENT = 1'b0, SNOOP_REQ = 1'b0;
    logic SNOOP_NEED_STALL = 1'b0, stall = 1'b0, ign_r = 1'b0, init_r = 1'b0;
    wire logic IGNORE_NUMERIC_ERROR, WARM_INIT, SNOOP_HIT_IN, SNOOP_HIT_MODIFIED_IN;
    wire logic FP_ERROR_OUT, INTERNAL_ERROR_OUT, SHUTDOWN_REQ, FP_EXCEPTION, SNOOP_HIT_OUT;
    wire logic SNOOP_HIT_OE, SNOOP_HIT_MODIFIED_OUT, SNOOP_HIT_MODIFIED_OE, SNOOP_DONE;
    wire logic PEER_STALL_SEEN, INT_REG_RESET, START_AT_RESET_VECTOR, BUILT_IN_SELF_TEST_RUN;
    int err_total = 0, samples_checked = 0, cyc_n = 0;
    always #20 CLK_SYS = ~CLK_SYS;
    err_init_unit dut (.*);
    peer_agent peer (.clk(CLK_SYS), .stall_req(stall), .ign_req(ign_r), .init_req(init_r),
        .hit(SNOOP_HIT_IN), .snoop_hit_modified(SNOOP_HIT_MODIFIED_IN), .ign(IGNORE_NUMERIC_ERROR),
        .init(WARM_INIT));
    task automatic end_of_test();
        if (err_total == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge CLK_SYS) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            err_total++;
            end_of_test();
        end
    end
    task automatic chk(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    // Count self-test cycles and look for the restart pulse
    task automatic watch(output int hi, output logic st);
        hi = 0;
        st = 1'b0;
        repeat (40) begin
            @(negedge CLK_SYS);
            hi += BUILT_IN_SELF_TEST_RUN;
            st |= START_AT_RESET_VECTOR;
        end
    endtask
    task automatic do_reset();
        @(posedge CLK_SYS) RST_B <= 1'b0;
        step(10);
        @(posedge CLK_SYS) RST_B <= 1'b1;
    endtask
    task automatic t_fp();
        @(posedge CLK_SYS) FP_ERROR_EVENT <= 1'b1;
        @(posedge CLK_SYS) FP_ERROR_EVENT <= 1'b0;
        step(1);
        @(negedge CLK_SYS) chk(FP_ERROR_OUT, 1'b1);
        for (int i = 0; i < 3; i++) begin
            @(posedge CLK_SYS) ign_r <= (i != 0);
            NATIVE_ERROR_BIT <= (i == 2);
            step(5);
            @(posedge CLK_SYS) FP_NONCTRL_ISSUE <= 1'b1;
            @(posedge CLK_SYS) FP_NONCTRL_ISSUE <= 1'b0;
            @(negedge CLK_SYS) chk(FP_EXCEPTION, i != 1);
        end
        @(posedge CLK_SYS) ign_r <= 1'b0;
        NATIVE_ERROR_BIT <= 1'b0;
    endtask
    task automatic t_internal_error_out();
        @(posedge CLK_SYS) INTERNAL_ERROR_EVENT <= 1'b1;
        @(posedge CLK_SYS) INTERNAL_ERROR_EVENT <= 1'b0;
        @(negedge CLK_SYS) chk(SHUTDOWN_REQ, 1'b1);
        step(5);
        @(negedge CLK_SYS) chk(INTERNAL_ERROR_OUT, 1'b1);
        @(posedge CLK_SYS) BUS_INIT <= 1'b1;
        @(posedge CLK_SYS) BUS_INIT <= 1'b0;
        @(negedge CLK_SYS) chk(INTERNAL_ERROR_OUT, 1'b0);
    endtask
    task automatic t_init();
        int n;
        logic st;
        @(posedge CLK_SYS) INTERNAL_ERROR_EVENT <= 1'b1;
        init_r <= 1'b1;
        @(posedge CLK_SYS) INTERNAL_ERROR_EVENT <= 1'b0;
        step(5);
        @(negedge CLK_SYS) chk(INT_REG_RESET, 1'b1);
        chk(INTERNAL_ERROR_OUT, 1'b0);
        chk(FP_ERROR_OUT, 1'b0);
        // Snoop stall while initialisation is held
        @(posedge CLK_SYS) {SNOOP_REQ, SNOOP_NEED_STALL} <= 2'h3;
        @(posedge CLK_SYS) {SNOOP_REQ, SNOOP_NEED_STALL} <= 2'h0;
        n = 0;
        repeat (8) @(negedge CLK_SYS) n += SNOOP_HIT_OUT && SNOOP_HIT_OE
            && SNOOP_HIT_MODIFIED_OUT && SNOOP_HIT_MODIFIED_OE;
        chk(n == `STALL_CYCLES, 1'b1);
        // Plain snoop answered while initialisation is held
        @(posedge CLK_SYS) SNOOP_REQ <= 1'b1;
        @(posedge CLK_SYS) SNOOP_REQ <= 1'b0;
        @(negedge CLK_SYS) chk(SNOOP_DONE, 1'b1);
        @(posedge CLK_SYS) init_r <= 1'b0;
        watch(n, st);
        chk(st, 1'b1);
        chk(n == 0, 1'b1);
        chk(INT_REG_RESET, 1'b0);
    endtask
    task automatic t_break();
        @(posedge CLK_SYS) stall <= 1'b1;
        STOP_CLOCK_REQ <= 1'b1;
        step(5);
        @(negedge CLK_SYS) chk(PEER_STALL_SEEN, 1'b1);
        chk(FP_ERROR_OUT, 1'b0);
        @(posedge CLK_SYS) stall <= 1'b0;
        PROBE_REQUEST <= 1'b1;
        step(3);
        @(posedge CLK_SYS) PROBE_REQUEST <= 1'b0;
        step(8);
        @(negedge CLK_SYS) chk(FP_ERROR_OUT, 1'b1);
        @(posedge CLK_SYS) STOP_CLOCK_REQ <= 1'b0;
        step(5);
        @(negedge CLK_SYS) chk(FP_ERROR_OUT, 1'b0);
    endtask
    task automatic t_built_in_self_test();
        int n;
        logic st;
        @(posedge CLK_SYS) init_r <= 1'b1;
        do_reset();
        watch(n, st);
        chk(n == `BUILT_IN_SELF_TEST_CYCLES, 1'b1);
        chk(st, 1'b1);
        @(posedge CLK_SYS) init_r <= 1'b0;
    endtask
    initial begin
        do_reset();
        t_fp();
        t_internal_error_out();
        t_init();
        t_break();
        t_built_in_self_test();
        end_of_test();
    end
endmodule
`default_nettype wire
